// ==== pst_defines.svh ====
// Purpose: Constants of the status and protection block
// Assumes: 20 MHz reference clock
// Notes: Offsets, field positions, opcodes and timing counts
`ifndef PST_DEFINES_SVH
`define PST_DEFINES_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define PST_OP_SET_LATCH 8'h06
`define PST_OP_CLR_LATCH 8'h04
`define PST_OP_RD_STATUS 8'h05
`define PST_OP_WR_STATUS 8'h01

// ----------------------------------------
// Status byte fields
// ----------------------------------------
`define PST_SR_LOCK 7
`define PST_SR_BG_HI 3
`define PST_SR_BG_LO 2
`define PST_SR_LATCH 1
`define PST_SR_BUSY 0
`define PST_SR_RESET 8'h00

// ----------------------------------------
// Guarded regions (upper address bits)
// ----------------------------------------
`define PST_BG_NONE 2'h0
`define PST_BG_QUARTER 2'h1
`define PST_BG_HALF 2'h2
`define PST_QUARTER_BASE 16'hC000
`define PST_HALF_BASE 16'h8000

// ----------------------------------------
// Timing
// ----------------------------------------
`define PST_CLK_NS 50
`define PST_TW_NS 5000000
`define PST_CNT_W 17

`endif

// ==== pst_pkg.sv ====
// Purpose: Types of the status and protection block
// Assumes: Nothing
// Notes: State of the front end and of the command engine is one packed struct each
package pst_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_WAIT,
		ST_RD_OUT,
		ST_WR_DATA,
		ST_WR_END
	} pst_state_t;

	typedef struct packed {
		logic cs_m;
		logic cs_s;
		logic cs_p;
		logic sck_m;
		logic sck_s;
		logic sck_p;
		logic d_m;
		logic d_s;
		logic w_m;
		logic w_s;
	} pst_front_t;

	typedef struct packed {
		pst_state_t st;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic lock;
		logic [1:0] bg;
		logic latch;
		logic busy;
		logic kind_status;
		logic [16:0] busy_cnt;
		logic [7:0] new_sr;
		logic miso_o;
		logic miso_oe;
		logic grant;
		logic deny;
		logic guard;
	} pst_core_t;

endpackage : pst_pkg

// ==== pst_spi_if.sv ====
// Purpose: Sampled serial events between front end and core
// Assumes: One reference clock domain
// Notes: Every edge event is a one-cycle pulse; din and wp_n are levels
`timescale 1ns/100ps
interface pst_spi_if;
	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic din;
	logic wp_n;

	modport front (
		output cs_fall,
		output cs_rise,
		output sck_rise,
		output sck_fall,
		output din,
		output wp_n
	);
	modport core (
		input cs_fall,
		input cs_rise,
		input sck_rise,
		input sck_fall,
		input din,
		input wp_n
	);
endinterface : pst_spi_if

// ==== pst_spi_front.sv ====
// Purpose: Synchronise serial pins and find their edges
// Assumes: Serial clock well below a quarter of the reference clock
// Notes: First stage flops are read only by the second stage
`timescale 1ns/100ps
module pst_spi_front (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic wp_n,
	pst_spi_if.front spi
);

	pst_pkg::pst_front_t q;
	pst_pkg::pst_front_t d;

	// ----------------------------------------
	// Two-flop synchronisers and edge history
	// ----------------------------------------
	always_comb begin
		d = q;
		d.cs_m = cs_n;
		d.cs_s = q.cs_m;
		d.cs_p = q.cs_s;
		d.sck_m = sck;
		d.sck_s = q.sck_m;
		d.sck_p = q.sck_s;
		d.d_m = mosi;
		d.d_s = q.d_m;
		d.w_m = wp_n;
		d.w_s = q.w_m;
	end

	// History resets low so select held low at reset shows no falling edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign spi.cs_fall = q.cs_p & ~q.cs_s;
	assign spi.cs_rise = ~q.cs_p & q.cs_s;
	assign spi.sck_rise = ~q.sck_p & q.sck_s;
	assign spi.sck_fall = q.sck_p & ~q.sck_s;
	assign spi.din = q.d_s;
	assign spi.wp_n = q.w_s;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_EDGE_EXCL: assert property (@(posedge clk) disable iff (!rst_n)
		!(spi.sck_rise && spi.sck_fall))
		else $error("serial clock edges overlap");

endmodule : pst_spi_front

// ==== pst_status_core.sv ====
// Purpose: Status byte, write latch and write guard of a serial memory
// Assumes: Serial mode 0, pins asynchronous to REF_CLK
// Notes: Array data path lives elsewhere and asks for writes here
`timescale 1ns/100ps
`include "pst_defines.svh"

// What this block does
// - Write latch must be set before array or status writes; only set-latch sets it.
// - After set or clear latch opcode, ignore input until select rises.
// - Latch clears at reset, on clear command, and when a write cycle ends.
// - Status read is answered at any time, even during a write cycle.
// - Status byte repeats while select stays low after status read.
// - Busy flag is 1 during a write cycle, 0 otherwise.
// - With latch clear, array and status writes are rejected.
// - Two guard bits, status-written, make a region reject array writes.
// - Guard bits change only outside hardware guard mode.
// - Lock bit 1 and guard pin low rejects status writes.
// - Status byte: lock, three zeros, upper guard, lower guard, latch, busy.
// - Status write needs opcode plus one byte, select raised before next clock.
// - Select rise after accepted status write starts the timed cycle.
// - Busy reads 1 during status cycle; latch clears when it ends.
// - New lock and guard values apply only after the cycle ends.
// - Status write leaves bits 6..4, 1, 0 alone; 6..4 read zero.
// - Lock bit 0 accepts status writes with latch set, any pin level.
// - Lock bit 1 with pin high accepts status writes with latch set.
// - Guard mode follows lock and pin in either order.
// - Only raising the guard pin leaves guard mode.
// - Bytes go MSB first; latch set 06, clear 04, status read 05.
// - Status write opcode is 01 followed by one data byte.
// - Guard field: none, C000-FFFF, 8000-FFFF, whole array.
// - Status write runs only if select rises after exactly sixteen clocks.
module pst_status_core #(
	parameter int TW_CYCLES = `PST_TW_NS / `PST_CLK_NS
) (
	input wire logic REF_CLK,
	input wire logic RST_N,
	input wire logic CS_N,
	input wire logic SCK,
	input wire logic MOSI,
	input wire logic WP_N,
	input wire logic ARR_WR_REQ,
	input wire logic [15:0] ARR_WR_ADDR,
	output logic MISO_O,
	output logic MISO_OE,
	output logic ARR_WR_GRANT,
	output logic ARR_WR_DENY,
	output logic CYCLE_BUSY,
	output logic GUARD_MODE
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] status_byte(input logic lock, input logic [1:0] bg,
		input logic latch, input logic busy);
		status_byte = {lock, 3'h0, bg, latch, busy};
	endfunction : status_byte

	function automatic logic guard_hit(input logic [1:0] bg, input logic [15:0] addr);
		logic hit;
		hit = 1'b1;
		unique case (bg)
			`PST_BG_NONE: hit = 1'b0;
			`PST_BG_QUARTER: hit = addr >= `PST_QUARTER_BASE;
			`PST_BG_HALF: hit = addr >= `PST_HALF_BASE;
			default: hit = 1'b1;
		endcase
		guard_hit = hit;
	endfunction : guard_hit

	localparam logic [16:0] TW_LOAD = 17'(TW_CYCLES - 1);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------
	// Pin front end
	// ----------------------------------------
	pst_spi_if spi ();

	pst_spi_front u_front (
		.clk(REF_CLK),
		.rst_n(rst_n),
		.cs_n(CS_N),
		.sck(SCK),
		.mosi(MOSI),
		.wp_n(WP_N),
		.spi(spi.front)
	);

	// ----------------------------------------
	// Command engine and status
	// ----------------------------------------
	pst_pkg::pst_core_t q;
	pst_pkg::pst_core_t d;
	logic hw_guard;
	logic arr_start;
	logic wr_status_ok;
	logic [7:0] rx_next;

	assign hw_guard = q.lock & ~spi.wp_n;
	assign arr_start = ARR_WR_REQ & q.latch & ~q.busy & ~guard_hit(q.bg, ARR_WR_ADDR);
	assign wr_status_ok = q.latch & ~q.busy & ~hw_guard & ~arr_start;
	assign rx_next = {q.sh[6:0], spi.din};

	always_comb begin
		d = q;
		d.grant = 1'b0;
		d.deny = 1'b0;
		d.guard = hw_guard;
		// Self-timed cycle
		if (q.busy) begin
			if (q.busy_cnt == '0) begin
				d.busy = 1'b0;
				d.latch = 1'b0;
				if (q.kind_status) begin
					d.lock = q.new_sr[`PST_SR_LOCK];
					d.bg = q.new_sr[`PST_SR_BG_HI:`PST_SR_BG_LO];
				end
			end else begin
				d.busy_cnt = q.busy_cnt - 17'd1;
			end
		end
		// Array write requests from the data path
		if (ARR_WR_REQ) begin
			if (arr_start) begin
				d.grant = 1'b1;
				d.busy = 1'b1;
				d.kind_status = 1'b0;
				d.busy_cnt = TW_LOAD;
			end else begin
				d.deny = 1'b1;
			end
		end
		// Serial command handling
		if (spi.cs_rise) begin
			if (q.st == pst_pkg::ST_WAIT && q.sh == `PST_OP_SET_LATCH) begin
				d.latch = 1'b1;
			end else if (q.st == pst_pkg::ST_WAIT && q.sh == `PST_OP_CLR_LATCH) begin
				d.latch = 1'b0;
			end else if (q.st == pst_pkg::ST_WR_END && wr_status_ok) begin
				d.busy = 1'b1;
				d.kind_status = 1'b1;
				d.busy_cnt = TW_LOAD;
				d.new_sr = q.sh;
			end
			d.st = pst_pkg::ST_IDLE;
			d.miso_oe = 1'b0;
		end else if (spi.cs_fall) begin
			d.st = pst_pkg::ST_OPCODE;
			d.cnt = 3'h0;
			d.miso_oe = 1'b0;
		end else if (spi.sck_rise) begin
			if (q.st == pst_pkg::ST_OPCODE || q.st == pst_pkg::ST_WR_DATA) begin
				d.sh = rx_next;
				d.cnt = q.cnt + 3'd1;
				if (q.cnt == 3'd7 && q.st == pst_pkg::ST_WR_DATA) begin
					d.st = pst_pkg::ST_WR_END;
				end else if (q.cnt == 3'd7) begin
					unique case (rx_next)
						`PST_OP_RD_STATUS: begin
							d.st = pst_pkg::ST_RD_OUT;
							d.tx = status_byte(q.lock, q.bg, q.latch, q.busy);
						end
						`PST_OP_WR_STATUS: d.st = pst_pkg::ST_WR_DATA;
						default: d.st = pst_pkg::ST_WAIT;
					endcase
				end
			end else if (q.st == pst_pkg::ST_WR_END) begin
				d.st = pst_pkg::ST_WAIT;
				// Drop the data byte so it cannot pass for a latch opcode at deselect
				d.sh = 8'h00;
			end
		end else if (spi.sck_fall && q.st == pst_pkg::ST_RD_OUT) begin
			d.miso_oe = 1'b1;
			d.miso_o = q.tx[7];
			d.tx = {q.tx[6:0], 1'b0};
			d.cnt = q.cnt + 3'd1;
			if (q.cnt == 3'd7) begin
				d.tx = status_byte(d.lock, d.bg, d.latch, d.busy);
			end
		end
	end

	always_ff @(posedge REF_CLK or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign MISO_O = q.miso_o;
	assign MISO_OE = q.miso_oe;
	assign ARR_WR_GRANT = q.grant;
	assign ARR_WR_DENY = q.deny;
	assign CYCLE_BUSY = q.busy;
	assign GUARD_MODE = q.guard;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!rst_n);

	AST_LATCH_SET: assert property (
		spi.cs_rise && q.st == pst_pkg::ST_WAIT && q.sh == `PST_OP_SET_LATCH |=> q.latch)
		else $error("set-latch command did not set the latch");

	AST_WAIT_HOLD: assert property (
		q.st == pst_pkg::ST_WAIT && !spi.cs_rise && !(q.busy && q.busy_cnt == '0)
		|=> q.st == pst_pkg::ST_WAIT && q.latch == $past(q.latch))
		else $error("wait state left before deselect");

	AST_LATCH_CLR_END: assert property (
		q.busy && q.busy_cnt == '0 && !(spi.cs_rise && q.st == pst_pkg::ST_WAIT)
		|=> !q.latch && !q.busy)
		else $error("latch not cleared at cycle end");

	AST_READ_DRIVES: assert property (
		q.st == pst_pkg::ST_RD_OUT && spi.sck_fall && !spi.cs_rise && !spi.cs_fall
		|=> MISO_OE && MISO_O == $past(q.tx[7]))
		else $error("status bit not driven");

	AST_READ_REPEAT: assert property (
		q.st == pst_pkg::ST_RD_OUT && spi.sck_fall && q.cnt == 3'd7 && !q.busy && !ARR_WR_REQ && !spi.cs_rise
		|=> q.tx == status_byte(q.lock, q.bg, q.latch, 1'b0))
		else $error("status byte not reloaded");

	AST_BUSY_LOAD: assert property (
		$rose(q.busy) |-> q.busy_cnt == TW_LOAD ##1 q.busy)
		else $error("cycle not started with full length");

	AST_REJECT_NO_LATCH: assert property (
		!q.latch && ARR_WR_REQ |=> ARR_WR_DENY && !ARR_WR_GRANT)
		else $error("array write granted without latch");

	AST_REGION_GUARD: assert property (
		ARR_WR_REQ && guard_hit(q.bg, ARR_WR_ADDR) |=> ARR_WR_DENY)
		else $error("guarded region accepted a write");

	AST_HW_REJECT: assert property (
		spi.cs_rise && q.st == pst_pkg::ST_WR_END && hw_guard && !q.busy && !ARR_WR_REQ
		|=> !q.busy)
		else $error("status write accepted in guard mode");

	AST_COMMIT_LATE: assert property (
		!$stable({q.lock, q.bg}) |-> $past(q.busy && q.busy_cnt == '0 && q.kind_status))
		else $error("lock or guard bits changed before cycle end");

	AST_DISCARD: assert property (
		q.st == pst_pkg::ST_WR_END && spi.sck_rise && !spi.cs_rise && !spi.cs_fall
		|=> q.st == pst_pkg::ST_WAIT)
		else $error("over-long status write not discarded");

	AST_ACCEPT: assert property (
		spi.cs_rise && q.st == pst_pkg::ST_WR_END && wr_status_ok |=> q.busy && q.kind_status)
		else $error("valid status write not started");

	AST_GUARD_PIN: assert property (
		q.lock && !spi.wp_n |=> GUARD_MODE)
		else $error("guard mode not entered");

	AST_HIZ_OPCODE: assert property (
		q.st == pst_pkg::ST_OPCODE |-> !MISO_OE)
		else $error("output driven during opcode");

	COV_LATCH_SET: cover property (spi.cs_rise && q.st == pst_pkg::ST_WAIT && q.sh == `PST_OP_SET_LATCH);
	COV_STATUS_COMMIT: cover property (q.busy && q.busy_cnt == '0 && q.kind_status);
	COV_READ_TWICE: cover property (q.st == pst_pkg::ST_RD_OUT && spi.sck_fall && q.cnt == 3'd7 && q.busy);
	COV_HW_REJECT: cover property (spi.cs_rise && q.st == pst_pkg::ST_WR_END && hw_guard && q.latch);

endmodule : pst_status_core

// ==== pst_host_model.sv ====
// Purpose: SPI host model that drives the serial pins of the status block
// Assumes: Mode 0, a 400 ns serial clock, stepped on falling REF_CLK edges
// Notes: A released data line reads as the inverse of its last driven bit
`timescale 1ns/100ps
module pst_host_model (
	input wire logic clk,
	output logic cs_n,
	output logic sck,
	output logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	logic last_q;
	logic miso_w;
	logic [7:0] r1;
	logic [7:0] r2;

	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		mosi = 1'b0;
		last_q = 1'b0;
	end

	always @(posedge clk) begin
		if (miso_oe)
			last_q <= miso_o;
	end

	assign miso_w = miso_oe ? miso_o : ~last_q;

	task half();
		repeat (4) @(negedge clk);
	endtask : half

	// ----------------------------------------
	// One byte, data changes while the serial clock is low
	// ----------------------------------------
	task xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi = tx[i];
			half();
			rx[i] = miso_w;
			sck = 1'b1;
			half();
			sck = 1'b0;
		end
	endtask : xfer

	// The serial clock stands still while the device is deselected
	task cmd(input logic [7:0] op, input logic [7:0] d, input int n);
		logic [7:0] rx;
		cs_n = 1'b0;
		half();
		xfer(op, rx);
		for (int k = 0; k < n; k++) begin
			xfer(d, rx);
			if (k == 0)
				r1 = rx;
			if (k == 1)
				r2 = rx;
		end
		half();
		cs_n = 1'b1;
		half();
		half();
	endtask : cmd
endmodule : pst_host_model

// ==== test_spi_eeprom_status_protection.sv ====
// Purpose: Self-checking bench of the status and protection block
// Assumes: Write cycle shortened to 400 reference clocks
// Notes: Expected status bytes come from the bench's own model
`timescale 1ns/100ps
module test_spi_eeprom_status_protection;
	localparam int TW = 400;
	logic ref_clk, rst_n, wp_n, req;
	logic [15:0] addr;
	logic cs_n, sck, mosi, miso_o, miso_oe, grant, deny, busy, guard;
	int error_cnt;
	int total_checks;
	logic lk, lt;
	logic [1:0] bg;
	logic [7:0] d;

	pst_host_model host_u (.clk(ref_clk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe));
	pst_status_core #(.TW_CYCLES(TW)) dut_u (.REF_CLK(ref_clk), .RST_N(rst_n), .CS_N(cs_n), .SCK(sck),
		.MOSI(mosi), .WP_N(wp_n), .ARR_WR_REQ(req), .ARR_WR_ADDR(addr), .MISO_O(miso_o), .MISO_OE(miso_oe),
		.ARR_WR_GRANT(grant), .ARR_WR_DENY(deny), .CYCLE_BUSY(busy), .GUARD_MODE(guard));

	// ----------------------------------------
	// Expectations and checking
	// ----------------------------------------
	function automatic logic [7:0] sr_exp(input logic b);
		return {lk, 3'h0, bg, lt, b};
	endfunction : sr_exp

	function automatic logic prot(input logic [1:0] f, input logic [15:0] a);
		return (f == 2'h3) || (f == 2'h2 && a >= 16'h8000) || (f == 2'h1 && a >= 16'hC000);
	endfunction : prot

	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	task wait_idle();
		int i;
		i = 0;
		while (busy !== 1'b0 && i < 1000) begin
			@(negedge ref_clk);
			i++;
		end
		if (i == 1000) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask : wait_idle

	// ----------------------------------------
	// Serial commands
	// ----------------------------------------
	task rd(input logic b);
		host_u.cmd(8'h05, 8'h00, 2);
		check(host_u.r1, sr_exp(b));
		check(host_u.r2, sr_exp(b));
	endtask : rd

	task latch(input logic s);
		host_u.cmd(s ? 8'h06 : 8'h04, 8'h00, 0);
		lt = s;
		rd(1'b0);
	endtask : latch

	task wr(input logic [7:0] v);
		logic ok;
		ok = lt && !(lk && !wp_n);
		host_u.cmd(8'h01, v, 1);
		check(busy, ok);
		if (ok) begin
			req = 1'b1;
			@(negedge ref_clk);
			req = 1'b0;
			check({grant, deny}, 2'h1);
		end
		rd(ok);
		if (ok) begin
			wait_idle();
			lk = v[7];
			bg = v[3:2];
			lt = 1'b0;
			rd(1'b0);
		end
	endtask : wr

	task arr(input logic [15:0] a);
		logic e;
		logic g;
		logic dn;
		e = !lt || prot(bg, a);
		req = 1'b1;
		addr = a;
		@(negedge ref_clk);
		req = 1'b0;
		g = grant;
		dn = deny;
		@(negedge ref_clk);
		g = g | grant;
		dn = dn | deny;
		check({g, dn}, {!e, e});
		if (!e) begin
			wait_idle();
			lt = 1'b0;
			rd(1'b0);
		end
	endtask : arr

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	initial begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		req = 1'b0;
		addr = 16'h0000;
		error_cnt = 0;
		total_checks = 0;
		{lk, bg, lt} = 4'h0;
		repeat (20) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		d = 8'($urandom(52));
		rd(1'b0);
		wr(8'h8C);
		latch(1'b1);
		latch(1'b0);
		$display("test latch done");
		repeat (4) begin
			latch(1'b1);
			d = 8'($urandom);
			wr(d);
		end
		latch(1'b1);
		host_u.cmd(8'h01, 8'hFF, 2);
		check(busy, 1'b0);
		rd(1'b0);
		latch(1'b0);
		host_u.cmd(8'h01, 8'h06, 2);
		rd(1'b0);
		latch(1'b1);
		$display("test status write done");
		wr(8'h00);
		wp_n = 1'b0;
		latch(1'b1);
		wr(8'h80);
		repeat (4) @(negedge ref_clk);
		check(guard, 1'b1);
		latch(1'b1);
		wr(8'h0C);
		wp_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		check(guard, 1'b0);
		latch(1'b1);
		wr(8'h00);
		$display("test guard mode done");
		for (int f = 0; f < 4; f++) begin
			latch(1'b1);
			wr({4'h0, 2'(f), 2'h0});
			arr(16'($urandom));
			latch(1'b1);
			arr(16'hBFFF);
			latch(1'b1);
			arr(16'hC000);
		end
		$display("test array gating done");
		tally_and_finish();
	end
endmodule : test_spi_eeprom_status_protection
